/* File: rtl/interrupt_vector_request_map.sv */
// interrupt request generation and fixed vector mapping
// assumes one 100 MHz clock; flag sources and enables arrive synchronous to it
//
// Functional notes
// - every vector but reset and the nine spares is driven by exactly one peripheral source
// - a source event sets that source's pending flag
// - each source has an enable bit written by software
// - request asserted only while enable and pending flag are both set
// - request holds until the pending flag is cleared, not a pulse
// - no request except the reset vector unless the global enable is set
// - reset 0, memscan nmi 1, voltage monitor 2, port a 3, port b 4
// - rtc counter at 6, periodic timer at 7
// - timer a underflows at 8 and 9, compares at 10 to 12
// - timer b at 13
// - comparator at 17
// - adc result ready at 20, window compare at 21
// - two-wire target at 24, controller at 25
// - serial peripheral interface at 26
// - uart receive 27, tx empty 28, transmit complete 29
// - nvm eeprom ready at 30
`timescale 1ns/100ps
`include "irq_map_defines.svh"

module interrupt_vector_request_map #(
	parameter int SRC_N = `SRC_COUNT
) (
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	input  wire logic [SRC_N-1:0] i_src_event,
	input  wire logic [SRC_N-1:0] i_src_flag_clear,
	input  wire logic [SRC_N-1:0] i_src_enable_wdata,
	input  wire logic             i_src_enable_we,
	input  wire logic             i_global_enable,
	input  wire logic             i_reset_request,
	output logic      [SRC_N-1:0] o_source_pending_flag,
	output logic      [SRC_N-1:0] o_source_irq_enable,
	output logic      [31:0]      o_vector_request
);

	// -------------------------------------------------------------------------
	// reset release
	// -------------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_meta_d;
	logic rst_sync_q;
	logic rst_sync_d;
	logic rst_n;

	// only the second stage is read; the first may still be settling
	always_comb begin
		rst_meta_d = 1'b1;
		rst_sync_d = rst_meta_q;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= rst_meta_d;
			rst_sync_q <= rst_sync_d;
		end
	end

	assign rst_n = rst_sync_q;

	// -------------------------------------------------------------------------
	// global enable
	// -------------------------------------------------------------------------
	logic global_q;
	logic global_d;

	// global gate sampled
	// one stage keeps the gate registered and glitch-free
	always_comb begin
		global_d = i_global_enable;
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			global_q <= `GLOBAL_ENABLE_RESET;
		end else begin
			global_q <= global_d;
		end
	end

	// -------------------------------------------------------------------------
	// source cells
	// -------------------------------------------------------------------------
	localparam logic [SRC_N-1:0] FLAG_RESET   = SRC_N'(`SRC_FLAG_RESET);
	localparam logic [SRC_N-1:0] ENABLE_RESET = SRC_N'(`SRC_ENABLE_RESET);

	wire logic [SRC_N-1:0]  pending;
	wire logic [SRC_N-1:0]  enabled;
	wire logic [SRC_N-1:0]  active;
	irq_map_pkg::vec_mask_t req_q;
	irq_map_pkg::vec_mask_t req_d;

	for (genvar k = 0; k < SRC_N; k++) begin : g_source
		irq_source_cell #(
			.FLAG_RESET   (FLAG_RESET[k]),
			.ENABLE_RESET (ENABLE_RESET[k])
		) u_cell (
			.i_clock        (i_clock),
			.i_rst_n        (rst_n),
			.i_event        (i_src_event[k]),
			.i_flag_clear   (i_src_flag_clear[k]),
			.i_enable_wdata (i_src_enable_wdata[k]),
			.i_enable_we    (i_src_enable_we),
			.i_global       (global_q),
			.o_flag         (pending[k]),
			.o_enable       (enabled[k]),
			.o_active       (active[k])
		);
	end

	// -------------------------------------------------------------------------
	// vector map
	// -------------------------------------------------------------------------
	always_comb begin
		req_d = '0;
		req_d[`VEC_SPARE_05]               = 1'b0;
		req_d[`VEC_SPARE_0E]               = 1'b0;
		req_d[`VEC_SPARE_0F]               = 1'b0;
		req_d[`VEC_SPARE_10]               = 1'b0;
		req_d[`VEC_SPARE_12]               = 1'b0;
		req_d[`VEC_SPARE_13]               = 1'b0;
		req_d[`VEC_SPARE_16]               = 1'b0;
		req_d[`VEC_SPARE_17]               = 1'b0;
		req_d[`VEC_SPARE_1F]               = 1'b0;
		req_d[`VEC_RESET]                  = i_reset_request;
		req_d[`VEC_MEMSCAN_NMI]            = active[`SRC_MEMSCAN_NMI];
		req_d[`VEC_VOLTAGE_LEVEL]          = active[`SRC_VOLTAGE_LEVEL];
		req_d[`VEC_PORT_A]                 = active[`SRC_PORT_A];
		req_d[`VEC_PORT_B]                 = active[`SRC_PORT_B];
		req_d[`VEC_RTC_COUNTER]            = active[`SRC_RTC_COUNTER];
		req_d[`VEC_PERIODIC_TIMER]         = active[`SRC_PERIODIC_TIMER];
		req_d[`VEC_TIMER_A_LOW_UNDERFLOW]  = active[`SRC_TIMER_A_LOW_UNDERFLOW];
		req_d[`VEC_TIMER_A_HIGH_UNDERFLOW] = active[`SRC_TIMER_A_HIGH_UNDERFLOW];
		req_d[`VEC_TIMER_A_COMPARE0]       = active[`SRC_TIMER_A_COMPARE0];
		req_d[`VEC_TIMER_A_COMPARE1]       = active[`SRC_TIMER_A_COMPARE1];
		req_d[`VEC_TIMER_A_COMPARE2]       = active[`SRC_TIMER_A_COMPARE2];
		req_d[`VEC_TIMER_B]                = active[`SRC_TIMER_B];
		req_d[`VEC_COMPARATOR]             = active[`SRC_COMPARATOR];
		req_d[`VEC_ADC_RESULT_READY]       = active[`SRC_ADC_RESULT_READY];
		req_d[`VEC_ADC_WINDOW_COMPARE]     = active[`SRC_ADC_WINDOW_COMPARE];
		req_d[`VEC_TWOWIRE_TARGET]         = active[`SRC_TWOWIRE_TARGET];
		req_d[`VEC_TWOWIRE_CONTROLLER]     = active[`SRC_TWOWIRE_CONTROLLER];
		req_d[`VEC_SERIAL_PERIPH]          = active[`SRC_SERIAL_PERIPH];
		req_d[`VEC_UART_RECEIVE_COMPLETE]  = active[`SRC_UART_RECEIVE_COMPLETE];
		req_d[`VEC_UART_TX_BUFFER_EMPTY]   = active[`SRC_UART_TX_BUFFER_EMPTY];
		req_d[`VEC_UART_TRANSMIT_COMPLETE] = active[`SRC_UART_TRANSMIT_COMPLETE];
		req_d[`VEC_NVM_EEPROM_READY]       = active[`SRC_NVM_EEPROM_READY];
	end

	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	// at most one source per vector; the nine spares have none
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end

	assign o_source_pending_flag = pending;
	assign o_source_irq_enable   = enabled;
	assign o_vector_request      = req_q;

endmodule // interrupt_vector_request_map

// -----------------------------------------------------------------------------
// source cell: pending flag, enable bit and gated request of one source
// -----------------------------------------------------------------------------
module irq_source_cell #(
	parameter logic FLAG_RESET   = 1'b0,
	parameter logic ENABLE_RESET = 1'b0
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_event,
	input  wire logic i_flag_clear,
	input  wire logic i_enable_wdata,
	input  wire logic i_enable_we,
	input  wire logic i_global,
	output logic      o_flag,
	output logic      o_enable,
	output logic      o_active
);

	// -------------------------------------------------------------------------
	// pending flag
	// -------------------------------------------------------------------------
	logic flag_q;
	logic flag_d;

	// event sets flag
	// set beats a same-cycle clear so no event is lost
	always_comb begin
		flag_d = (flag_q & ~i_flag_clear) | i_event;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_q <= FLAG_RESET;
		end else begin
			flag_q <= flag_d;
		end
	end

	// -------------------------------------------------------------------------
	// enable bit
	// -------------------------------------------------------------------------
	logic enable_q;
	logic enable_d;

	always_comb begin
		enable_d = i_enable_we ? i_enable_wdata : enable_q;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_q <= ENABLE_RESET;
		end else begin
			enable_q <= enable_d;
		end
	end

	// -------------------------------------------------------------------------
	// request gate
	// -------------------------------------------------------------------------
	// global enable, flag and enable
	assign o_active = i_global & flag_q & enable_q;
	assign o_flag   = flag_q;
	assign o_enable = enable_q;

endmodule // irq_source_cell

/* File: rtl/irq_map_defines.svh */
// constants for the interrupt vector request map
// assumes inclusion by bare name from the rtl folder
`ifndef IRQ_MAP_DEFINES_SVH
`define IRQ_MAP_DEFINES_SVH

// -----------------------------------------------------------------------------
// vector geometry
// -----------------------------------------------------------------------------
`define VEC_COUNT                     32
`define VEC_IDX_W                     5

// -----------------------------------------------------------------------------
// fixed vector numbers
// -----------------------------------------------------------------------------
`define VEC_RESET                     5'h00
`define VEC_MEMSCAN_NMI               5'h01
`define VEC_VOLTAGE_LEVEL             5'h02
`define VEC_PORT_A                    5'h03
`define VEC_PORT_B                    5'h04
`define VEC_RTC_COUNTER               5'h06
`define VEC_PERIODIC_TIMER            5'h07
`define VEC_TIMER_A_LOW_UNDERFLOW     5'h08
`define VEC_TIMER_A_HIGH_UNDERFLOW    5'h09
`define VEC_TIMER_A_COMPARE0          5'h0a
`define VEC_TIMER_A_COMPARE1          5'h0b
`define VEC_TIMER_A_COMPARE2          5'h0c
`define VEC_TIMER_B                   5'h0d
`define VEC_COMPARATOR                5'h11
`define VEC_ADC_RESULT_READY          5'h14
`define VEC_ADC_WINDOW_COMPARE        5'h15
`define VEC_TWOWIRE_TARGET            5'h18
`define VEC_TWOWIRE_CONTROLLER        5'h19
`define VEC_SERIAL_PERIPH             5'h1a
`define VEC_UART_RECEIVE_COMPLETE     5'h1b
`define VEC_UART_TX_BUFFER_EMPTY      5'h1c
`define VEC_UART_TRANSMIT_COMPLETE    5'h1d
`define VEC_NVM_EEPROM_READY          5'h1e

// -----------------------------------------------------------------------------
// vectors with no source behind them
// -----------------------------------------------------------------------------
`define VEC_SPARE_05                  5'h05
`define VEC_SPARE_0E                  5'h0e
`define VEC_SPARE_0F                  5'h0f
`define VEC_SPARE_10                  5'h10
`define VEC_SPARE_12                  5'h12
`define VEC_SPARE_13                  5'h13
`define VEC_SPARE_16                  5'h16
`define VEC_SPARE_17                  5'h17
`define VEC_SPARE_1F                  5'h1f

// -----------------------------------------------------------------------------
// source bit positions in the flag and enable vectors
// -----------------------------------------------------------------------------
`define SRC_COUNT                     22
`define SRC_MEMSCAN_NMI               0
`define SRC_VOLTAGE_LEVEL             1
`define SRC_PORT_A                    2
`define SRC_PORT_B                    3
`define SRC_RTC_COUNTER               4
`define SRC_PERIODIC_TIMER            5
`define SRC_TIMER_A_LOW_UNDERFLOW     6
`define SRC_TIMER_A_HIGH_UNDERFLOW    7
`define SRC_TIMER_A_COMPARE0          8
`define SRC_TIMER_A_COMPARE1          9
`define SRC_TIMER_A_COMPARE2          10
`define SRC_TIMER_B                   11
`define SRC_COMPARATOR                12
`define SRC_ADC_RESULT_READY          13
`define SRC_ADC_WINDOW_COMPARE        14
`define SRC_TWOWIRE_TARGET            15
`define SRC_TWOWIRE_CONTROLLER        16
`define SRC_SERIAL_PERIPH             17
`define SRC_UART_RECEIVE_COMPLETE     18
`define SRC_UART_TX_BUFFER_EMPTY      19
`define SRC_UART_TRANSMIT_COMPLETE    20
`define SRC_NVM_EEPROM_READY          21

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define SRC_FLAG_RESET                22'h000000
`define SRC_ENABLE_RESET              22'h000000
`define GLOBAL_ENABLE_RESET           1'b0

`endif

/* File: rtl/irq_map_pkg.sv */
// types for the interrupt vector request map
// assumes the defines header is compiled alongside
package irq_map_pkg;
	typedef logic [4:0] vec_idx_t;
	typedef logic [21:0] src_vec_t;
	typedef logic [31:0] vec_mask_t;
endpackage

/* File: dv/irq_source_model.sv */
// peripheral side: turns a fire command into a one-cycle source event
// assumes fire and index change at the falling edge by non-blocking assignment
`timescale 1ns/100ps
module irq_source_model (
	input  wire logic        i_clock,
	input  wire logic        i_fire,
	input  wire logic [4:0]  i_src,
	output logic      [21:0] o_src_event = 22'h000000
);
	// events move on the falling edge, clear of the sampling edge
	always @(negedge i_clock) begin
		o_src_event <= i_fire ? (22'h000001 << i_src) : 22'h000000;
	end
endmodule // irq_source_model

/* File: dv/interrupt_vector_request_map_asserts.sv */
// checker for the vector request map, sees only its top ports
// assumes one clock domain and the default source bit order
`timescale 1ns/100ps
module irq_map_checker #(
	parameter int SRC_N = 22
) (
	input wire logic             i_clock,
	input wire logic             i_nrst,
	input wire logic [SRC_N-1:0] i_src_event,
	input wire logic [SRC_N-1:0] i_src_flag_clear,
	input wire logic [SRC_N-1:0] i_src_enable_wdata,
	input wire logic             i_src_enable_we,
	input wire logic             i_global_enable,
	input wire logic             i_reset_request,
	input wire logic [SRC_N-1:0] o_source_pending_flag,
	input wire logic [SRC_N-1:0] o_source_irq_enable,
	input wire logic [31:0]      o_vector_request
);
	localparam int VEC[22] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 17, 20, 21, 24, 25, 26,
		27, 28, 29, 30};
	function automatic logic [31:0] map_req(input logic [21:0] f);
		logic [31:0] r;
		r = 32'h00000000;
		for (int k = 0; k < 22; k++) r[VEC[k]] = f[k];
		return r;
	endfunction
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	a_event_sets_flag: assert property ((|i_src_event) |=>
		(o_source_pending_flag & $past(i_src_event)) == $past(i_src_event)) else $error("flag");
	a_flag_no_spurious: assert property ((o_source_pending_flag
		& ~$past(o_source_pending_flag) & ~$past(i_src_event)) == 0) else $error("spurious");
	a_clear_drops_flag: assert property ((|(i_src_flag_clear & ~i_src_event)) |=>
		(o_source_pending_flag & $past(i_src_flag_clear) & ~$past(i_src_event)) == 0)
		else $error("clear");
	a_enable_loads: assert property (i_src_enable_we |=>
		o_source_irq_enable == $past(i_src_enable_wdata)) else $error("enable load");
	a_enable_keeps: assert property (!i_src_enable_we |=>
		$stable(o_source_irq_enable)) else $error("enable kept");
	a_request_gated: assert property ((o_vector_request & 32'hfffffffe) == map_req(
		$past(o_source_pending_flag) & $past(o_source_irq_enable)
		& {22{$past(i_global_enable, 2)}})) else $error("request map");
	a_unused_quiet: assert property ((o_vector_request & 32'h80cdc020) == 0)
		else $error("unused vector");
	a_reset_vector: assert property (i_reset_request [*3] |-> o_vector_request[0])
		else $error("reset vector");
	c_any_request: cover property (|o_vector_request[31:1]);
	c_reset_request: cover property (o_vector_request[0]);
	c_flag_cleared: cover property (|(i_src_flag_clear & o_source_pending_flag));
endmodule // irq_map_checker

bind interrupt_vector_request_map irq_map_checker #(.SRC_N(SRC_N)) chk (.i_clock(i_clock),
	.i_nrst(i_nrst), .i_src_event(i_src_event), .i_src_flag_clear(i_src_flag_clear),
	.i_src_enable_wdata(i_src_enable_wdata), .i_src_enable_we(i_src_enable_we),
	.i_global_enable(i_global_enable), .i_reset_request(i_reset_request),
	.o_source_pending_flag(o_source_pending_flag), .o_source_irq_enable(o_source_irq_enable),
	.o_vector_request(o_vector_request));

/* File: dv/test_interrupt_vector_request_map.sv */
// self-checking bench for the vector request map
// assumes the source model and the bound checker are compiled first
`timescale 1ns/100ps
module test_interrupt_vector_request_map;
	logic        i_clock = 1'b0;
	logic        i_nrst = 1'b0;
	logic        we = 1'b0, glob = 1'b0, rreq = 1'b0, fire = 1'b0;
	logic [4:0]  src = 5'h00;
	logic [21:0] clr = 22'h000000, en = 22'h000000, ev, flg, ena;
	logic [31:0] req;
	int          n_errors = 0;
	int          n_tests = 0;
	int          vec[22] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 17, 20, 21, 24, 25, 26,
		27, 28, 29, 30};
	initial forever #5 i_clock = ~i_clock;
	irq_source_model src_model (.i_clock(i_clock), .i_fire(fire), .i_src(src), .o_src_event(ev));
	interrupt_vector_request_map uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_src_event(ev),
		.i_src_flag_clear(clr), .i_src_enable_wdata(en), .i_src_enable_we(we),
		.i_global_enable(glob), .i_reset_request(rreq), .o_source_pending_flag(flg),
		.o_source_irq_enable(ena), .o_vector_request(req));
	task automatic tick(input int n); repeat (n) @(negedge i_clock); endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// event reaches flag after one edge, request after the next
	task automatic pulse(input int k);
		src <= 5'(k);
		fire <= 1'b1;
		tick(1);
		fire <= 1'b0;
		tick(2);
	endtask
	task automatic set_en(input logic [21:0] v, input logic g);
		en <= v;
		we <= 1'b1;
		glob <= g;
		tick(1);
		we <= 1'b0;
		tick(2);
		cmp("enable", 32'(v), 32'(ena));
	endtask
	task automatic clear_src(input int k);
		clr <= 22'h000001 << k;
		tick(1);
		clr <= 22'h0;
		tick(2);
	endtask
	task automatic map_walk;
		set_en(22'h3fffff, 1'b1);
		for (int k = 0; k < 22; k++) begin
			pulse(k);
			cmp("flag", 32'(22'h000001 << k), 32'(flg));
			cmp("vector", 32'h00000001 << vec[k], req);
			tick(3);
			cmp("held", 32'h00000001 << vec[k], req);
			clear_src(k);
			cmp("cleared", 32'h0, req);
		end
	endtask
	task automatic gating;
		set_en(22'h000000, 1'b1);
		pulse(12);
		cmp("masked", 32'h0, req);
		set_en(22'h001000, 1'b1);
		cmp("enabled", 32'h00020000, req);
		set_en(22'h001000, 1'b0);
		cmp("global off", 32'h0, req);
		clear_src(12);
	endtask
	task automatic reset_vector;
		rreq <= 1'b1;
		tick(3);
		cmp("reset vector", 32'h1, req);
		rreq <= 1'b0;
		tick(3);
		cmp("reset vector off", 32'h0, req);
	endtask
	// a reset in mid-run drops flags, enables and requests at once
	task automatic mid_reset;
		set_en(22'h000001, 1'b1);
		pulse(0);
		cmp("pre-reset vector", 32'h00000002, req);
		i_nrst <= 1'b0;
		tick(1);
		cmp("reset flags", 32'h0, 32'(flg));
		cmp("reset enables", 32'h0, 32'(ena));
		cmp("reset vectors", 32'h0, req);
		i_nrst <= 1'b1;
		tick(3);
		cmp("after reset", 32'h0, req);
	endtask
	task automatic complete_run;
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		tick(8);
		i_nrst <= 1'b1;
		tick(3);
		cmp("reset requests", 32'h0, req);
		map_walk();
		gating();
		reset_vector();
		mid_reset();
		complete_run();
	end
endmodule // test_interrupt_vector_request_map
